// ---- local_mem_model.sv ----
// local memory model holding the message lists
`timescale 1ns/10ps
`default_nettype none
module local_mem_model #(parameter int LAT = 2) (
  // memory port of the block
  input wire logic core_clk, rst_n, mem_req_r, mem_wr_r,
  input wire logic [31:0] mem_addr_r, mem_wdata_r,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  logic [31:0] mem [0:15];
  int cnt;
  // lists are in place before the host uses the ports
  initial for (int i = 0; i < 16; i++) mem[i] = 32'h5a5a_5a00 + i;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_ack <= 1'b0;
      cnt <= 0;
      mem_rdata <= 32'h0;
    end else begin
      mem_ack <= 1'b0;
      // garbage between answers, so a late sample shows up
      mem_rdata <= ~mem_rdata;
      if (mem_req_r && !mem_ack) begin
        cnt <= cnt + 1;
        if (cnt == LAT) begin
          cnt <= 0;
          mem_ack <= 1'b1;
          mem_rdata <= mem[mem_addr_r[5:2]];
          if (mem_wr_r) mem[mem_addr_r[5:2]] <= mem_wdata_r;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- lut_msg_ports.v ----
// lookup table indirect access and message queue ports of a bus bridge
//
// Behaviour
// RULE_01: 8-bit lookup offset register at 028h, readable and writable.
// RULE_02: any read or write of the data register starts a table entry access.
// RULE_03: software loads the offset register before touching the data register.
// RULE_04: byte enables ignored on data register; writes update the whole 32-bit entry.
// RULE_05: data register write stores value into entry selected by current offset.
// RULE_06: data register read returns entry selected by current offset.
// RULE_07: entry bit 0 valid, bit 3 prefetchable, upper bits translated base.
// RULE_08: entry bits 2:1 and 7:4 read back as zero.
// RULE_09: table storage is not reset; contents undefined until written.
// RULE_10: primary read of inbound port returns head of inbound free list.
// RULE_11: primary write of inbound port appends to tail of inbound post list.
// RULE_12: primary read of outbound port returns head of outbound post list.
// RULE_13: primary write of outbound port appends to tail of outbound free list.
// RULE_14: secondary bus accesses to queue ports act as reserved, no queue effect.
// RULE_15: local processor sets up lists and pointers before host uses ports.
// RULE_16: table reachable through offset/data pair for I/O and memory cycles.
// RULE_17: after each pop or push the matching head or tail pointer advances.
`timescale 1ns/10ps
`default_nettype none
`include "lutq_regs.vh"
module lut_msg_ports #(
  parameter LUT_WORDS = `LUT_WORDS,
  parameter FIFO_DEPTH = `FIFO_WORDS
) (
  // clock and reset
  input wire core_clk,
  input wire rst_n,
  // register access port
  input wire reg_req,
  input wire reg_wr,
  input wire reg_from_primary,
  input wire reg_is_io,
  input wire [7:0] reg_addr,
  input wire [3:0] reg_be,
  input wire [31:0] reg_wdata,
  output wire reg_ready,
  output wire rd_valid,
  input wire rd_ready,
  output wire [31:0] rd_data,
  // pointer initialisation from the local processor
  input wire ptr_load,
  input wire [31:0] ifree_head_init,
  input wire [31:0] ipost_tail_init,
  input wire [31:0] opost_head_init,
  input wire [31:0] ofree_tail_init,
  // local memory port
  output reg mem_req_r,
  output reg mem_wr_r,
  output reg [31:0] mem_addr_r,
  output reg [31:0] mem_wdata_r,
  input wire mem_ack,
  input wire [31:0] mem_rdata,
  // current list pointers
  output reg [31:0] ifree_head_r,
  output reg [31:0] ipost_tail_r,
  output reg [31:0] opost_head_r,
  output reg [31:0] ofree_tail_r,
  output wire [7:0] lut_entry_index
);
  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  localparam ST_IDLE = 2'b00;
  localparam ST_MEM = 2'b01;
  localparam ST_PUSH = 2'b10;
  localparam SEL_NONE = 3'd0;
  localparam SEL_IN_RD = 3'd1;
  localparam SEL_IN_WR = 3'd2;
  localparam SEL_OUT_RD = 3'd3;
  localparam SEL_OUT_WR = 3'd4;

  function hit;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      hit = (addr[7:2] == ofs[7:2]);
    end
  endfunction

  // entries are read back with reserved bits forced low
  function [31:0] clean_entry;
    input [31:0] raw;
    begin
      clean_entry = raw & ~`ENTRY_RSVD_MASK; // RULE_08 RULE_07
    end
  endfunction

  reg [7:0] index_r;
  reg [1:0] state_r;
  reg [2:0] sel_r;
  reg [31:0] lut_mem [0:LUT_WORDS-1];
  reg fifo_in_valid;
  reg [31:0] fifo_in_data;
  wire fifo_in_ready;
  wire idle;
  wire take;
  wire [31:0] lut_rd;
  wire [5:0] lut_slot;

  assign lut_entry_index = index_r;
  assign idle = (state_r == ST_IDLE);
  // a read needs room in the fifo so back-pressure stalls the bus
  // no take while pointers load, else a queue access would be swallowed
  assign reg_ready = idle && !ptr_load && (reg_wr || fifo_in_ready);
  assign take = reg_req && reg_ready;
  // byte offset selects a word, low two bits dropped
  assign lut_slot = index_r[`LUT_IDX_LSB+5:`LUT_IDX_LSB];
  assign lut_rd = lut_mem[lut_slot];

  // ----------------------------------------------------------------
  // lookup table
  // ----------------------------------------------------------------
  // no reset on the array: it is storage, not control state
  always @(posedge core_clk) begin
    if (take && reg_wr && hit(reg_addr, `LUT_ENTRY_WORD_OFS)) begin // RULE_02 RULE_16
      lut_mem[lut_slot] <= reg_wdata; // RULE_04 RULE_05 RULE_09
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      index_r <= 8'h00;
    end else if (take && reg_wr && hit(reg_addr, `LUT_ENTRY_INDEX_OFS)) begin
      index_r <= reg_wdata[7:0]; // RULE_01
    end
  end

  // ----------------------------------------------------------------
  // read data into fifo
  // ----------------------------------------------------------------
  always @* begin
    fifo_in_valid = 1'b0;
    fifo_in_data = `ZERO_WORD;
    if (take && !reg_wr) begin
      if (hit(reg_addr, `LUT_ENTRY_INDEX_OFS)) begin
        fifo_in_valid = 1'b1;
        fifo_in_data = {24'h000000, index_r}; // RULE_01
      end else if (hit(reg_addr, `LUT_ENTRY_WORD_OFS)) begin
        fifo_in_valid = 1'b1;
        fifo_in_data = clean_entry(lut_rd); // RULE_02 RULE_06
      end else if (!reg_from_primary || (!hit(reg_addr, `INBOUND_MSG_PORT_OFS) &&
                   !hit(reg_addr, `OUTBOUND_MSG_PORT_OFS))) begin
        fifo_in_valid = 1'b1; // RULE_14
      end
    end else if (state_r == ST_MEM && mem_ack && !mem_wr_r) begin
      fifo_in_valid = 1'b1;
      fifo_in_data = mem_rdata; // RULE_10 RULE_12
    end
  end

  msg_fifo #(
    .WIDTH(32),
    .DEPTH(FIFO_DEPTH),
    .AW(4)
  ) u_rd_fifo (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd_data)
  );

  // ----------------------------------------------------------------
  // queue port sequencer
  // ----------------------------------------------------------------
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      sel_r <= SEL_NONE;
      mem_req_r <= 1'b0;
      mem_wr_r <= 1'b0;
      mem_addr_r <= `ZERO_WORD;
      mem_wdata_r <= `ZERO_WORD;
      ifree_head_r <= `ZERO_WORD;
      ipost_tail_r <= `ZERO_WORD;
      opost_head_r <= `ZERO_WORD;
      ofree_tail_r <= `ZERO_WORD;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (ptr_load) begin
            ifree_head_r <= ifree_head_init; // RULE_15
            ipost_tail_r <= ipost_tail_init;
            opost_head_r <= opost_head_init;
            ofree_tail_r <= ofree_tail_init;
          end else if (take && reg_from_primary) begin // RULE_14
            if (hit(reg_addr, `INBOUND_MSG_PORT_OFS)) begin
              state_r <= ST_MEM;
              mem_req_r <= 1'b1;
              mem_wr_r <= reg_wr;
              mem_wdata_r <= reg_wdata;
              mem_addr_r <= reg_wr ? ipost_tail_r : ifree_head_r; // RULE_10 RULE_11
              sel_r <= reg_wr ? SEL_IN_WR : SEL_IN_RD;
            end else if (hit(reg_addr, `OUTBOUND_MSG_PORT_OFS)) begin
              state_r <= ST_MEM;
              mem_req_r <= 1'b1;
              mem_wr_r <= reg_wr;
              mem_wdata_r <= reg_wdata;
              mem_addr_r <= reg_wr ? ofree_tail_r : opost_head_r; // RULE_12 RULE_13
              sel_r <= reg_wr ? SEL_OUT_WR : SEL_OUT_RD;
            end
          end
        end
        ST_MEM: begin
          if (mem_ack) begin
            mem_req_r <= 1'b0;
            state_r <= ST_PUSH;
          end
        end
        ST_PUSH: begin
          state_r <= ST_IDLE;
          sel_r <= SEL_NONE;
          case (sel_r)
            SEL_IN_RD: ifree_head_r <= ifree_head_r + `PTR_STEP; // RULE_17
            SEL_IN_WR: ipost_tail_r <= ipost_tail_r + `PTR_STEP; // RULE_17
            SEL_OUT_RD: opost_head_r <= opost_head_r + `PTR_STEP; // RULE_17
            SEL_OUT_WR: ofree_tail_r <= ofree_tail_r + `PTR_STEP; // RULE_17
            default: ifree_head_r <= ifree_head_r;
          endcase
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end
  // unused: byte enables are ignored throughout, io and memory cycles behave alike
  wire unused_ok;
  assign unused_ok = &{1'b0, reg_be, reg_is_io};
endmodule
`default_nettype wire

// ---- lut_msg_ports_checker.sv ----
// assertions on the lookup table and queue ports
`timescale 1ns/10ps
`default_nettype none
module lut_msg_ports_checker (
  input wire logic core_clk, rst_n, reg_req, reg_wr, reg_from_primary,
  input wire logic reg_ready, rd_valid, mem_req_r, mem_wr_r, mem_ack,
  input wire logic [7:0] reg_addr, lut_entry_index,
  input wire logic [31:0] reg_wdata, mem_addr_r, mem_wdata_r, ifree_head_r, ipost_tail_r
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire logic tk = reg_req && reg_ready;
  wire logic q0 = tk && reg_from_primary && reg_addr == 8'h40;
  wire logic ak = mem_req_r && mem_ack && !mem_wr_r;
  chk_index_load:
    assert property (tk && reg_wr && reg_addr == 8'h28 |=>
      lut_entry_index == $past(reg_wdata[7:0])) else $error("bad index");
  chk_reg_read:
    assert property (tk && !reg_wr && reg_addr[7:3] == 5'h05 |=> rd_valid)
    else $error("no read data");
  chk_inb_pop:
    assert property (q0 && !reg_wr |=> mem_req_r && !mem_wr_r &&
      mem_addr_r == $past(ifree_head_r)) else $error("bad pop");
  chk_inb_push:
    assert property (q0 && reg_wr |=> mem_req_r && mem_wr_r &&
      mem_addr_r == $past(ipost_tail_r) && mem_wdata_r == $past(reg_wdata))
    else $error("bad push");
  chk_sec_quiet:
    assert property (tk && !reg_from_primary |=> !mem_req_r) else $error("queue touched");
  chk_req_hold:
    assert property (mem_req_r && !mem_ack |=> mem_req_r && $stable(mem_addr_r))
    else $error("request dropped");
  chk_pop_answer:
    assert property (ak |=> rd_valid && !mem_req_r && !reg_ready) else $error("no pop data");
  chk_head_step:
    assert property (ak && mem_addr_r == ifree_head_r |=> ##1
      ifree_head_r == $past(ifree_head_r, 2) + 32'h4) else $error("head stuck");
  cover property (q0 && !reg_wr);
  cover property (tk && !reg_from_primary);
  cover property (reg_req && !reg_ready && !mem_req_r);
endmodule
bind lut_msg_ports lut_msg_ports_checker chk (.*);
`default_nettype wire

// ---- lut_msg_ports_tb_top.sv ----
// self-checking bench for the lookup table and queue ports
`timescale 1ns/10ps
`default_nettype none
module lut_msg_ports_tb_top;
  logic core_clk = 0, rst_n = 0, reg_req = 0, reg_wr = 0, reg_from_primary = 1;
  logic reg_is_io = 0, rd_ready = 1, ptr_load = 0;
  logic [7:0] reg_addr = 8'h00;
  logic [3:0] reg_be = 4'hf;
  logic [31:0] reg_wdata = 32'h0, ifree_head_init = 32'h0, ipost_tail_init = 32'h10;
  logic [31:0] opost_head_init = 32'h20, ofree_tail_init = 32'h30, q;
  wire reg_ready, rd_valid, mem_req_r, mem_wr_r, mem_ack;
  wire [7:0] lut_entry_index;
  wire [31:0] rd_data, mem_addr_r, mem_wdata_r, mem_rdata;
  wire [31:0] ifree_head_r, ipost_tail_r, opost_head_r, ofree_tail_r;
  int err_total = 0, total_checks = 0, cyc = 0;
  lut_msg_ports DUT (.*);
  local_mem_model mdl (.*);
  initial forever #25 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      close_out();
    end
  end
  task automatic chk(string s, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic acc(logic w, logic [7:0] a, logic [31:0] d);
    @(negedge core_clk);
    reg_req = 1;
    reg_wr = w;
    reg_addr = a;
    reg_wdata = d;
    #1;
    while (reg_ready !== 1'b1) @(negedge core_clk);
    @(negedge core_clk);
    reg_req = 0;
  endtask
  task automatic rd(logic [7:0] a);
    acc(0, a, 32'h0);
    while (rd_valid !== 1'b1) @(negedge core_clk);
    q = rd_data;
    @(negedge core_clk);
  endtask
  task automatic idle();
    while (reg_ready !== 1'b1) @(negedge core_clk);
  endtask
  function automatic logic [31:0] ptrs();
    return {ifree_head_r[7:0], ipost_tail_r[7:0], opost_head_r[7:0], ofree_tail_r[7:0]};
  endfunction
  task automatic t_lut();
    reg_be = 4'h0;
    // table is never reset, so only written entries are read back
    for (int i = 0; i < 3; i++) begin
      reg_is_io = i[0];
      acc(1, 8'h28, 32'hfc - i * 32'h7e);
      chk("index", 32'hfc - i * 32'h7e, {24'h0, lut_entry_index});
      acc(1, 8'h2c, 32'hffff_ffff - i * 32'h1357_9bd1);
    end
    for (int i = 0; i < 3; i++) begin
      acc(1, 8'h28, 32'hfc - i * 32'h7e);
      rd(8'h28);
      chk("index read", 32'hfc - i * 32'h7e, q);
      rd(8'h2c);
      chk("entry", (32'hffff_ffff - i * 32'h1357_9bd1) & ~32'hf6, q);
    end
    reg_be = 4'hf;
    $display("lut test done");
  endtask
  task automatic t_q();
    ptr_load = 1;
    repeat (2) @(negedge core_clk);
    ptr_load = 0;
    rd(8'h40);
    chk("inbound pop", 32'h5a5a_5a00, q);
    rd(8'h40);
    chk("inbound pop", 32'h5a5a_5a01, q);
    acc(1, 8'h40, 32'hc0de_0001);
    idle();
    chk("inbound post", 32'hc0de_0001, mdl.mem[4]);
    rd(8'h44);
    chk("outbound pop", 32'h5a5a_5a08, q);
    acc(1, 8'h44, 32'hc0de_0002);
    idle();
    chk("outbound free", 32'hc0de_0002, mdl.mem[12]);
    chk("pointers", 32'h0814_2434, ptrs());
    $display("queue test done");
  endtask
  task automatic t_sec();
    reg_from_primary = 0;
    rd(8'h40);
    chk("secondary read", 32'h0, q);
    acc(1, 8'h44, 32'hdead_0003);
    reg_from_primary = 1;
    rd(8'h80);
    chk("unmapped read", 32'h0, q);
    chk("pointers", 32'h0814_2434, ptrs());
    chk("free list", 32'h5a5a_5a0d, mdl.mem[13]);
    $display("secondary test done");
  endtask
  task automatic t_fifo();
    acc(1, 8'h28, 32'hfc);
    rd_ready = 0;
    repeat (16) acc(0, 8'h28, 32'h0);
    @(negedge core_clk);
    reg_req = 1;
    @(negedge core_clk);
    chk("ready when full", 32'h0, {31'h0, reg_ready});
    reg_req = 0;
    rd_ready = 1;
    for (int i = 0; i < 16; i++) begin
      chk("drain", 32'hfc, rd_data);
      @(negedge core_clk);
    end
    chk("empty", 32'h0, {31'h0, rd_valid});
    $display("fifo test done");
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
    rst_n = 1;
    t_lut();
    t_q();
    t_sec();
    t_fifo();
    close_out();
  end
endmodule
`default_nettype wire

// ---- lutq_regs.vh ----
// register offsets, entry fields and sizes for the lookup table and message queue ports
`ifndef LUTQ_REGS_VH
`define LUTQ_REGS_VH
`define LUT_ENTRY_INDEX_OFS 8'h28
`define LUT_ENTRY_WORD_OFS 8'h2c
`define INBOUND_MSG_PORT_OFS 8'h40
`define OUTBOUND_MSG_PORT_OFS 8'h44
`define ENTRY_VALID_BIT 0
`define ENTRY_PREF_BIT 3
`define ENTRY_RSVD_MASK 32'h0000_00f6
`define LUT_WORDS 64
`define LUT_IDX_LSB 2
`define FIFO_WORDS 16
`define PTR_STEP 32'h0000_0004
`define ZERO_WORD 32'h0000_0000
`endif

// ---- msg_fifo.v ----
// parameterised valid/ready fifo used in the register read-data path
`timescale 1ns/10ps
`default_nettype none
module msg_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // clock and reset
  input wire core_clk,
  input wire rst_n,
  // fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // drain side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_r;
  reg [AW-1:0] rd_ptr_r;
  reg [AW:0] count_r;
  wire push;
  wire pop;
  assign in_ready = (count_r != DEPTH);
  assign out_valid = (count_r != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push && !pop) begin
        count_r <= count_r + {{AW{1'b0}}, 1'b1};
      end else if (pop && !push) begin
        count_r <= count_r - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule
`default_nettype wire
